// ---- hw/tcr_pkg.sv ----
package tcr_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 12;      // byte address width
  localparam int          REG_W       = 8;       // control register width
  localparam int          CH_W        = 5;       // monitor channel number width

  // ------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [9:0]  FRA_IDX     = 10'h019; // framer_a_tx_control_five
  localparam logic [9:0]  FRB_IDX     = 10'h0B9; // framer_b_tx_control_five
  localparam logic [9:0]  STAT_IDX    = 10'h01A; // line status, read only

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          CRC_POS     = 7;       // tx_crc6_variant_select
  localparam int          LOOP_POS    = 6;       // local_loop_enable
  localparam int          AIS_POS     = 5;       // line_all_ones_force
  localparam int          CH_MSB      = 4;       // tx_monitor_channel_bit4
  localparam int          CH_LSB      = 0;       // tx_monitor_channel_bit0
  localparam logic [7:0]  FRA_WMASK   = 8'hFF;   // all bits stored
  localparam logic [7:0]  FRB_WMASK   = 8'h9F;   // bits 6 and 5 unassigned
  localparam logic [7:0]  REG_RST     = 8'h00;   // control value after reset
  localparam int          STAT_AIS    = 0;       // status: all-ones active
  localparam int          STAT_PHASE  = 1;       // status: current mark rail

  // ------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // all-ones bit timing from the master clock
  // ------------------------------------------------------------
  localparam int          CLK_NS      = 50;      // sys_clk_i period
  localparam int          AIS_BIT_NS  = 648;     // one t1 bit, longest
  localparam int          AIS_DIV_CYC = AIS_BIT_NS / CLK_NS;  // rounds down

endpackage

// ---- hw/tcr_line_out.sv ----
module tcr_line_out #(
  parameter int AIS_DIV = tcr_pkg::AIS_DIV_CYC  // master cycles per line bit
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // control
  input  wire logic line_all_ones_force_i,
  // normal transmit data
  input  wire logic tx_positive_data_in_i,
  input  wire logic tx_negative_data_in_i,
  // line side
  output logic      line_out_tip_o,
  output logic      line_out_ring_o,
  output logic      ais_active_o,
  output logic      mark_phase_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (AIS_DIV < 2 || AIS_DIV > 255)
  begin : g_bad_div
    $error("AIS_DIV must lie between 2 and 255");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] div;    // master clock divider
    logic       phase;  // which rail carries the current mark
    logic       ais;    // all-ones being sent
    logic       tip;    // registered tip
    logic       ring;   // registered ring
  } tcr_line_type;

  tcr_line_type st_r;
  tcr_line_type st_nxt;
  logic         bit_en;  // one pulse per line bit

  // divider runs free so the pattern never waits on the data clock
  assign bit_en = (st_r.div == 8'(AIS_DIV - 1));

  // next state
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.div = bit_en ? 8'h00 : st_r.div + 8'h01;
    st_nxt.ais = line_all_ones_force_i;
    if (line_all_ones_force_i)
    begin
      // every bit a mark, alternating rails: unframed all ones
      if (bit_en)
      begin
        st_nxt.phase = ~st_r.phase;
      end
      st_nxt.tip  = ~st_nxt.phase;
      st_nxt.ring = st_nxt.phase;
    end
    else
    begin
      // pass-through, one register stage of delay
      st_nxt.tip  = tx_positive_data_in_i;
      st_nxt.ring = tx_negative_data_in_i;
    end
  end

  // register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign line_out_tip_o  = st_r.tip;
  assign line_out_ring_o = st_r.ring;
  assign ais_active_o    = st_r.ais;
  assign mark_phase_o    = st_r.phase;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_ais_one_rail: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    line_all_ones_force_i |=> (line_out_tip_o ^ line_out_ring_o))
    else $error("all-ones output must mark exactly one rail");

  chk_pass_through: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !line_all_ones_force_i |=> (line_out_tip_o == $past(tx_positive_data_in_i))
      && (line_out_ring_o == $past(tx_negative_data_in_i)))
    else $error("normal data not passed to the line");

  chk_ais_timing: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (line_all_ones_force_i && $past(line_all_ones_force_i) && !bit_en)
      |=> $stable(line_out_tip_o))
    else $error("all-ones mark changed off the master bit pulse");

endmodule

// ---- hw/tcr_top.sv ----
// Function
// - crc6 select bit picks standard or japanese
// - framer a bit 6 switches local loopback
// - ais bit forces all ones, else pass-through
// - all-ones pattern timed from master clock
//
// Implementation choice: the AXI4-Lite register port.
module tcr_top #(
  parameter int AIS_DIV = tcr_pkg::AIS_DIV_CYC  // master cycles per line bit
) (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // axi4-lite write address
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [tcr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]                s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  // axi4-lite write response
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  output logic [1:0]                     s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  input  wire logic [tcr_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]                s_axi_arprot_i,
  // axi4-lite read data
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  // transmit slot timing per framer
  input  wire logic                      tx_slot_valid_a_i,
  input  wire logic [tcr_pkg::CH_W-1:0]  tx_slot_index_a_i,
  input  wire logic                      tx_slot_valid_b_i,
  input  wire logic [tcr_pkg::CH_W-1:0]  tx_slot_index_b_i,
  // normal transmit line data, framer a
  input  wire logic                      tx_positive_data_in_i,
  input  wire logic                      tx_negative_data_in_i,
  // framer controls
  output logic                           tx_crc6_variant_select_a_o,
  output logic                           tx_crc6_variant_select_b_o,
  output logic                           local_loop_enable_o,
  output logic                           line_all_ones_force_o,
  // channel monitor steering
  output logic [tcr_pkg::CH_W-1:0]       tx_monitor_channel_a_o,
  output logic [tcr_pkg::CH_W-1:0]       tx_monitor_channel_b_o,
  output logic                           tx_channel_monitor_reg_load_a_o,
  output logic                           tx_channel_monitor_reg_load_b_o,
  // line outputs
  output logic                           line_out_tip_o,
  output logic                           line_out_ring_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic                        aw_held;  // write address taken
    logic [tcr_pkg::ADDR_W-1:0]  awaddr;   // held write address
    logic                        w_held;   // write data taken
    logic [7:0]                  wdata;    // held low byte
    logic                        wstrb0;   // low lane enabled
    logic                        bvalid;   // write answer pending
    logic [1:0]                  bresp;    // write answer code
    logic                        rvalid;   // read answer pending
    logic [1:0]                  rresp;    // read answer code
    logic [7:0]                  rdata;    // read byte
    logic [7:0]                  fra;      // framer_a_tx_control_five
    logic [7:0]                  frb;      // framer_b_tx_control_five
    logic [1:0]                  load;     // monitor copy strobes
  } tcr_top_type;

  tcr_top_type                   st_r;
  tcr_top_type                   st_nxt;
  logic                          do_write;  // both halves present
  logic [9:0]                    wr_idx;    // write word index
  logic [9:0]                    rd_idx;    // read word index
  logic                          ais_active;
  logic                          mark_phase;
  logic [1:0]                    slot_valid;
  logic [1:0][tcr_pkg::CH_W-1:0] slot_index;
  logic [1:0][tcr_pkg::CH_W-1:0] chan_sel;
  logic [1:0]                    slot_hit;

  // protection bits carry no meaning for this slave
  logic                          unused_prot;
  assign unused_prot = ^{s_axi_awprot_i, s_axi_arprot_i, s_axi_wdata_i[31:8],
                         s_axi_wstrb_i[3:1]};

  // ------------------------------------------------------------
  // handshakes
  // ------------------------------------------------------------
  // one write at a time: halves are refused until the answer is taken
  assign s_axi_awready_o = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready_o  = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready_o = !st_r.rvalid;
  assign do_write        = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign wr_idx          = st_r.awaddr[tcr_pkg::ADDR_W-1:2];
  assign rd_idx          = s_axi_araddr_i[tcr_pkg::ADDR_W-1:2];

  // ------------------------------------------------------------
  // channel select per framer
  // ------------------------------------------------------------
  assign slot_valid = {tx_slot_valid_b_i, tx_slot_valid_a_i};
  assign slot_index = {tx_slot_index_b_i, tx_slot_index_a_i};
  // bit 4 is the msb of the channel number in both registers
  assign chan_sel[0] = st_r.fra[tcr_pkg::CH_MSB:tcr_pkg::CH_LSB];
  assign chan_sel[1] = st_r.frb[tcr_pkg::CH_MSB:tcr_pkg::CH_LSB];

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_framer
    // copy strobe when the selected channel passes
    assign slot_hit[gi] = slot_valid[gi] && (slot_index[gi] == chan_sel[gi]);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.load = slot_hit;
    // take address and data in either order
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata_i[7:0];
      st_nxt.wstrb0 = s_axi_wstrb_i[0];
    end
    // commit once both halves are held
    if (do_write)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = tcr_pkg::RESP_OKAY;
      case (wr_idx)
        tcr_pkg::FRA_IDX:
        begin
          if (st_r.wstrb0)
          begin
            st_nxt.fra = st_r.wdata & tcr_pkg::FRA_WMASK;
          end
        end
        tcr_pkg::FRB_IDX:
        begin
          // unassigned bits are never stored, so they read back zero
          if (st_r.wstrb0)
          begin
            st_nxt.frb = st_r.wdata & tcr_pkg::FRB_WMASK;
          end
        end
        tcr_pkg::STAT_IDX:
        begin
          // status is read only; a write is accepted and dropped
          st_nxt.bresp = tcr_pkg::RESP_OKAY;
        end
        default:
        begin
          st_nxt.bresp = tcr_pkg::RESP_SLVERR;
        end
      endcase
    end
    // write answer taken
    if (st_r.bvalid && s_axi_bready_i)
    begin
      st_nxt.bvalid = 1'b0;
    end
    // read answer taken
    if (st_r.rvalid && s_axi_rready_i)
    begin
      st_nxt.rvalid = 1'b0;
    end
    // read request: answer in the next cycle
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = tcr_pkg::RESP_OKAY;
      case (rd_idx)
        tcr_pkg::FRA_IDX:
        begin
          st_nxt.rdata = st_r.fra;
        end
        tcr_pkg::FRB_IDX:
        begin
          st_nxt.rdata = st_r.frb;
        end
        tcr_pkg::STAT_IDX:
        begin
          st_nxt.rdata                     = 8'h00;
          st_nxt.rdata[tcr_pkg::STAT_AIS]   = ais_active;
          st_nxt.rdata[tcr_pkg::STAT_PHASE] = mark_phase;
        end
        default:
        begin
          st_nxt.rdata = 8'h00;
          st_nxt.rresp = tcr_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_r     <= '0;
      st_r.fra <= tcr_pkg::REG_RST;
      st_r.frb <= tcr_pkg::REG_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_bvalid_o                  = st_r.bvalid;
  assign s_axi_bresp_o                   = st_r.bresp;
  assign s_axi_rvalid_o                  = st_r.rvalid;
  assign s_axi_rresp_o                   = st_r.rresp;
  assign s_axi_rdata_o                   = {24'h000000, st_r.rdata};
  assign tx_crc6_variant_select_a_o      = st_r.fra[tcr_pkg::CRC_POS];
  assign tx_crc6_variant_select_b_o      = st_r.frb[tcr_pkg::CRC_POS];
  assign local_loop_enable_o             = st_r.fra[tcr_pkg::LOOP_POS];
  assign line_all_ones_force_o           = st_r.fra[tcr_pkg::AIS_POS];
  assign tx_monitor_channel_a_o          = chan_sel[0];
  assign tx_monitor_channel_b_o          = chan_sel[1];
  assign tx_channel_monitor_reg_load_a_o = st_r.load[0];
  assign tx_channel_monitor_reg_load_b_o = st_r.load[1];

  // ------------------------------------------------------------
  // line output stage, framer a only
  // ------------------------------------------------------------
  tcr_line_out #(
    .AIS_DIV (AIS_DIV)
  ) u_line (
    .sys_clk_i             (sys_clk_i),
    .srst_i                (srst_i),
    .line_all_ones_force_i (st_r.fra[tcr_pkg::AIS_POS]),
    .tx_positive_data_in_i (tx_positive_data_in_i),
    .tx_negative_data_in_i (tx_negative_data_in_i),
    .line_out_tip_o        (line_out_tip_o),
    .line_out_ring_o       (line_out_ring_o),
    .ais_active_o          (ais_active),
    .mark_phase_o          (mark_phase)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_wr_a;
    do_write && st_r.wstrb0 && (wr_idx == tcr_pkg::FRA_IDX);
  endsequence

  sequence s_wr_b;
    do_write && st_r.wstrb0 && (wr_idx == tcr_pkg::FRB_IDX);
  endsequence

  chk_crc6_select: assert property (s_wr_b |=>
    tx_crc6_variant_select_b_o == $past(st_r.wdata[7]))
    else $error("crc6 select of framer b not taken from write");

  chk_loop_enable: assert property (s_wr_a |=>
    local_loop_enable_o == $past(st_r.wdata[6]))
    else $error("loopback enable not taken from write");

  chk_ais_force: assert property (s_wr_a |=>
    line_all_ones_force_o == $past(st_r.wdata[5]))
    else $error("all-ones force not taken from write");

  chk_chan_copy: assert property (tx_slot_valid_a_i
    && tx_slot_index_a_i == st_r.fra[4:0] |=> tx_channel_monitor_reg_load_a_o)
    else $error("selected channel not copied");

  chk_chan_skip: assert property (!slot_hit[1] |=> !tx_channel_monitor_reg_load_b_o)
    else $error("unselected channel copied");

  chk_frb_unassigned: assert property (s_wr_b |=> st_r.frb[6:5] == 2'b00
    && tx_monitor_channel_b_o == $past(st_r.wdata[4:0]))
    else $error("framer b unassigned bits or channel number wrong");

  chk_write_answer: assert property (do_write |=> s_axi_bvalid_o)
    else $error("write answer missing");

endmodule

// ---- verification/tcr_host_model.sv ----
module tcr_host_model (
  // clock
  input  wire logic        sys_clk_i,
  // write address and data
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [11:0]      awaddr_o,
  output logic [2:0]       awprot_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  // write response
  input  wire logic        bvalid_i,
  output logic             bready_o,
  input  wire logic [1:0]  bresp_i,
  // read address and data
  output logic             arvalid_o,
  input  wire logic        arready_i,
  output logic [11:0]      araddr_o,
  output logic [2:0]       arprot_o,
  input  wire logic        rvalid_i,
  output logic             rready_o,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i
);
  // ----------------------------------------------------------
  // idle bus; answer channels always accepted
  // ----------------------------------------------------------
  initial
  begin
    {awvalid_o, wvalid_o, arvalid_o} = 3'h0;
    {awaddr_o, araddr_o, awprot_o, arprot_o} = 30'h0;
    {wdata_o, wstrb_o} = 36'h0;
    bready_o = 1'b1;  // held high so no answer is missed
    rready_o = 1'b1;
  end

  // write: offer both halves, release each when taken, then wait for answer
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_t;
    logic w_t;
    logic aw_d;
    logic w_d;
    logic b_t;
    // start right after a rising edge, whatever edge the caller stood on
    @(posedge sys_clk_i);
    awaddr_o  <= a;
    awvalid_o <= 1'b1;
    wdata_o   <= {24'h0, d};
    wstrb_o   <= s;
    wvalid_o  <= 1'b1;
    aw_d = 1'b0;
    w_d  = 1'b0;
    b_t  = 1'b0;
    while (!(aw_d && w_d))
    begin
      @(negedge sys_clk_i);
      aw_t = awvalid_o && awready_i;  // settled value seen at next edge
      w_t  = wvalid_o && wready_i;
      @(posedge sys_clk_i);
      if (aw_t) awvalid_o <= 1'b0;
      if (w_t) wvalid_o <= 1'b0;
      aw_d = aw_d | aw_t;
      w_d  = w_d | w_t;
    end
    while (!b_t)
    begin
      @(negedge sys_clk_i);
      b_t  = bvalid_i;
      resp = bresp_i;
      @(posedge sys_clk_i);
    end
  endtask

  // read: hold address until taken, then wait for data
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_d;
    logic r_t;
    // start right after a rising edge, whatever edge the caller stood on
    @(posedge sys_clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    ar_d = 1'b0;
    r_t  = 1'b0;
    while (!ar_d)
    begin
      @(negedge sys_clk_i);
      ar_d = arready_i;
      @(posedge sys_clk_i);
    end
    arvalid_o <= 1'b0;
    while (!r_t)
    begin
      @(negedge sys_clk_i);
      r_t  = rvalid_i;
      d    = rdata_i;
      resp = rresp_i;
      @(posedge sys_clk_i);
    end
  endtask
endmodule

// ---- verification/tcr_top_tb.sv ----
module tcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  localparam int          DIV   = 3;  // short line bit keeps the run brief
  localparam logic [11:0] A_FRA = {tcr_pkg::FRA_IDX, 2'b00};
  localparam logic [11:0] A_FRB = {tcr_pkg::FRB_IDX, 2'b00};
  localparam logic [11:0] A_ST  = {tcr_pkg::STAT_IDX, 2'b00};
  logic        clk, srst, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [2:0]  awp, arp;
  logic [31:0] wd, rdat, rd_d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, rsp;
  logic        va, vb, pos, neg, crc_a, crc_b, loop, frc, ld_a, ld_b, tip, ring;
  logic [4:0]  ia, ib, ch_a, ch_b;
  logic [13:0] ctl;
  int          n_fail, check_count, cyc, swaps;
  logic [1:0]  prev;
  logic [15:0] tbl [5] = '{16'h8000, 16'h409F, 16'h1081, 16'h0110, 16'h0000};
  assign ctl = {crc_a, crc_b, loop, frc, ch_a, ch_b};

  always #25 clk = ~clk;  // 20 MHz

  tcr_top #(.AIS_DIV(DIV)) i_tcr_top (.sys_clk_i(clk), .srst_i(srst),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(awp),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(arp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .tx_slot_valid_a_i(va), .tx_slot_index_a_i(ia), .tx_slot_valid_b_i(vb),
    .tx_slot_index_b_i(ib), .tx_positive_data_in_i(pos), .tx_negative_data_in_i(neg),
    .tx_crc6_variant_select_a_o(crc_a), .tx_crc6_variant_select_b_o(crc_b),
    .local_loop_enable_o(loop), .line_all_ones_force_o(frc),
    .tx_monitor_channel_a_o(ch_a), .tx_monitor_channel_b_o(ch_b),
    .tx_channel_monitor_reg_load_a_o(ld_a), .tx_channel_monitor_reg_load_b_o(ld_b),
    .line_out_tip_o(tip), .line_out_ring_o(ring));

  tcr_host_model i_tcr_host_model (.sys_clk_i(clk), .awvalid_o(awv), .awready_i(awr),
    .awaddr_o(awa), .awprot_o(awp), .wvalid_o(wv), .wready_i(wr_), .wdata_o(wd),
    .wstrb_o(ws), .bvalid_i(bv), .bready_o(br), .bresp_i(bresp), .arvalid_o(arv),
    .arready_i(arr), .araddr_o(ara), .arprot_o(arp), .rvalid_i(rv), .rready_o(rr),
    .rdata_i(rdat), .rresp_i(rresp));

  // ----------------------------------------------------------
  // compare, bus helpers, closing
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] d);
    i_tcr_host_model.wr(a, d, 4'h1, rsp);
    chk(rsp, tcr_pkg::RESP_OKAY);
  endtask

  task automatic get(input logic [11:0] a, input logic [7:0] e);
    i_tcr_host_model.rd(a, rd_d, rsp);
    chk(rsp, tcr_pkg::RESP_OKAY);
    chk(rd_d, {24'h000000, e});
  endtask

  // control outputs expected from the two register values
  function automatic logic [13:0] exp_ctl(input logic [7:0] a, input logic [7:0] b);
    return {a[7], b[7], a[6], a[5], a[4:0], b[4:0]};
  endfunction

  task automatic finish_test();
    $display("checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // all framer and line outputs low and both registers zero after reset
  task automatic t_reset();
    @(negedge clk);
    chk({ctl, ld_a, ld_b, tip, ring}, 32'h0);
    get(A_FRA, 8'h00);
    get(A_FRB, 8'h00);
  endtask

  // each field but the all-ones force reaches its output; framer b unassigned bits written zero
  task automatic t_regs();
    foreach (tbl[i])
    begin
      put(A_FRA, tbl[i][15:8]);
      put(A_FRB, tbl[i][7:0]);
      @(negedge clk);
      chk(ctl, exp_ctl(tbl[i][15:8], tbl[i][7:0]));
      get(A_FRA, tbl[i][15:8]);
      get(A_FRB, tbl[i][7:0]);
    end
  endtask

  // sweep every slot index back to back, a pulse only on the chosen one
  task automatic t_slot();
    logic [4:0] p;
    put(A_FRA, 8'h13);
    put(A_FRB, 8'h0C);
    for (int i = 0; i <= 32; i++)
    begin
      @(posedge clk);
      va <= (i < 32);
      vb <= (i < 32);
      ia <= i[4:0];
      ib <= i[4:0] + 5'h01;
      @(negedge clk);
      p = 5'(i - 1);
      if (i > 0) chk({ld_a, ld_b}, {p == 5'h13, p == 5'h0B});
    end
    @(negedge clk);
    chk({ld_a, ld_b}, 2'h0);
  endtask

  // pass-through, then forced all-ones from the master clock divider
  task automatic t_line();
    put(A_FRA, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      pos <= i[0];
      neg <= i[1];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({tip, ring}, {i[0], i[1]});
    end
    put(A_FRA, 8'h20);
    repeat (2) @(negedge clk);
    prev  = {tip, ring};
    swaps = 0;
    for (int i = 0; i < 30; i++)
    begin
      @(posedge clk);
      pos <= ~pos;  // line inputs must be ignored
      @(negedge clk);
      chk(tip ^ ring, 1);
      if ({tip, ring} !== prev) swaps++;
      prev = {tip, ring};
    end
    chk(swaps, 30 / DIV);
    // status shows all-ones active; rail bit masked, its phase is free running
    i_tcr_host_model.rd(A_ST, rd_d, rsp);
    chk(rsp, tcr_pkg::RESP_OKAY);
    chk(rd_d & 32'hFFFFFFFD, 32'h00000001);
  endtask

  // unmapped place, read-only place, empty strobe
  task automatic t_bus();
    put(A_FRA, 8'h13);
    // all-ones now off: status bit 0 low
    i_tcr_host_model.rd(A_ST, rd_d, rsp);
    chk(rsp, tcr_pkg::RESP_OKAY);
    chk(rd_d & 32'hFFFFFFFD, 32'h00000000);
    i_tcr_host_model.rd(12'h000, rd_d, rsp);
    chk(rsp, tcr_pkg::RESP_SLVERR);
    chk(rd_d, 32'h00000000);
    i_tcr_host_model.wr(12'h004, 8'hFF, 4'h1, rsp);
    chk(rsp, tcr_pkg::RESP_SLVERR);
    i_tcr_host_model.wr(A_FRA, 8'hFF, 4'h0, rsp);
    chk(rsp, tcr_pkg::RESP_OKAY);
    put(A_ST, 8'hFF);
    get(A_FRA, 8'h13);
  endtask

  // ----------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    {clk, srst, va, vb, pos, neg, ia, ib} = 16'h4000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_slot();
    t_line();
    t_bus();
    @(posedge clk);
    srst <= 1'b1;  // reset again in mid-run
    @(posedge clk);
    srst <= 1'b0;
    t_reset();
    finish_test();
  end
endmodule
